// *** src/ldct_channel.sv ***
`include "ldct_map.svh"

module ldct_channel (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        tick_i,
    input  wire logic        qsec_i,
    input  wire logic        sec_i,
    input  wire logic [15:0] change_i,
    input  wire logic        loop_open_i,
    input  wire logic [31:0] cfg_i,
    input  wire logic        delay_en_i,
    input  wire logic        ext_en_i,
    output logic             call_n_o,
    output logic             led_o,
    output logic             tuned_o,
    output logic             detect_o
);
    // ------------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------------
    ldct_pkg::ldct_mode_t mode;
    ldct_pkg::ldct_sens_t sens;
    logic [5:0]           delay_s;
    logic [5:0]           ext_q;
    logic [15:0]          thr;
    logic [15:0]          baseline_reg;
    logic [15:0]          net_change;
    logic                 detect;
    logic [14:0]          hold_reg;
    logic [7:0]           tune_reg;
    logic [6:0]           tmr_reg;
    logic                 call_reg;
    ldct_pkg::ldct_state_t state_reg;

    assign mode    = ldct_pkg::ldct_mode_t'(cfg_i[`LDCT_CFG_MODE_LSB +: 2]);
    assign sens    = ldct_pkg::ldct_sens_t'(cfg_i[`LDCT_CFG_SENS_LSB +: 2]);
    // delay setting is clamped to the adjustable span
    assign delay_s = (cfg_i[`LDCT_CFG_DELAY_LSB +: 6] > 6'(`LDCT_DELAY_MAX_S)) ?
                     6'(`LDCT_DELAY_MAX_S) : cfg_i[`LDCT_CFG_DELAY_LSB +: 6];
    assign ext_q   = cfg_i[`LDCT_CFG_EXT_LSB +: 6];

    // ------------------------------------------------------------------
    // threshold and tracking
    // ------------------------------------------------------------------
    always_comb begin
        case (sens)
            ldct_pkg::LDCT_SENS_LOW:  thr = `LDCT_THR_LOW;
            ldct_pkg::LDCT_SENS_MID:  thr = `LDCT_THR_MID;
            ldct_pkg::LDCT_SENS_HIGH: thr = `LDCT_THR_HIGH;
            default:                  thr = `LDCT_THR_LOW;
        endcase
    end

    assign net_change = (change_i > baseline_reg) ? (change_i - baseline_reg) : 16'h0000;
    assign detect     = (net_change >= thr) && (state_reg != ldct_pkg::LDCT_ST_TUNE);

    // baseline follows slow drift while no vehicle is seen, or after a three-minute hold
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baseline_reg <= 16'h0000;
        end else if (state_reg == ldct_pkg::LDCT_ST_TUNE) begin
            baseline_reg <= change_i;
        end else if (sec_i && (!detect || hold_reg == 15'(`LDCT_HOLD_TICKS))) begin
            if (change_i > baseline_reg) begin
                baseline_reg <= baseline_reg + `LDCT_TRACK_STEP;
            end else if (change_i < baseline_reg) begin
                baseline_reg <= baseline_reg - `LDCT_TRACK_STEP;
            end
        end
    end

    // presence hold: tracking frozen for the first three minutes of a detection, so a call holds past three minutes
    always_ff @(posedge clk_i) begin
        if (rst_i || !detect) begin
            hold_reg <= 15'h0000;
        end else if (tick_i && hold_reg != 15'(`LDCT_HOLD_TICKS)) begin
            hold_reg <= hold_reg + 15'h0001;
        end
    end

    // ------------------------------------------------------------------
    // call sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ldct_pkg::LDCT_ST_TUNE;
            tune_reg  <= 8'h00;
            tmr_reg   <= 7'h00;
        end else begin
            case (state_reg)
                ldct_pkg::LDCT_ST_TUNE: begin
                    if (tick_i) begin
                        tune_reg <= tune_reg + 8'h01;
                    end
                    if (tune_reg == 8'(`LDCT_TUNE_TICKS)) begin
                        state_reg <= ldct_pkg::LDCT_ST_IDLE;
                    end
                end
                ldct_pkg::LDCT_ST_IDLE: begin
                    tmr_reg <= 7'h00;
                    if (detect && mode != ldct_pkg::LDCT_MODE_OFF) begin
                        if (mode == ldct_pkg::LDCT_MODE_PULSE) begin
                            state_reg <= ldct_pkg::LDCT_ST_PULSE;
                        end else if (delay_en_i && delay_s != 6'h00) begin
                            state_reg <= ldct_pkg::LDCT_ST_DELAY;
                        end else begin
                            state_reg <= ldct_pkg::LDCT_ST_CALL;
                        end
                    end
                end
                ldct_pkg::LDCT_ST_DELAY: begin
                    if (!detect) begin
                        state_reg <= ldct_pkg::LDCT_ST_IDLE;
                    end else if (tmr_reg[5:0] >= delay_s) begin
                        state_reg <= ldct_pkg::LDCT_ST_CALL;
                        tmr_reg   <= 7'h00;
                    end else if (sec_i) begin
                        tmr_reg <= tmr_reg + 7'h01;
                    end
                end
                ldct_pkg::LDCT_ST_CALL: begin
                    tmr_reg <= 7'h00;
                    if (!detect) begin
                        state_reg <= (ext_en_i && ext_q != 6'h00) ?
                                     ldct_pkg::LDCT_ST_EXTEND : ldct_pkg::LDCT_ST_IDLE;
                    end
                end
                ldct_pkg::LDCT_ST_EXTEND: begin
                    if (detect) begin
                        state_reg <= ldct_pkg::LDCT_ST_CALL;
                    end else if (tmr_reg[5:0] >= ext_q) begin
                        state_reg <= ldct_pkg::LDCT_ST_IDLE;
                    end else if (qsec_i) begin
                        tmr_reg <= tmr_reg + 7'h01;
                    end
                end
                ldct_pkg::LDCT_ST_PULSE: begin
                    if (tmr_reg >= 7'(`LDCT_PULSE_TICKS)) begin
                        state_reg <= ldct_pkg::LDCT_ST_WAIT_CLEAR;
                    end else if (tick_i) begin
                        tmr_reg <= tmr_reg + 7'h01;
                    end
                end
                ldct_pkg::LDCT_ST_WAIT_CLEAR: begin
                    if (!detect) begin
                        state_reg <= ldct_pkg::LDCT_ST_IDLE;
                    end
                end
                default: state_reg <= ldct_pkg::LDCT_ST_IDLE;
            endcase
            if (mode == ldct_pkg::LDCT_MODE_OFF && state_reg != ldct_pkg::LDCT_ST_TUNE) begin
                state_reg <= ldct_pkg::LDCT_ST_IDLE;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            call_reg <= 1'b0;
            led_o    <= 1'b0;
            detect_o <= 1'b0;
            tuned_o  <= 1'b0;
        end else begin
            if (mode == ldct_pkg::LDCT_MODE_OFF) begin
                call_reg <= 1'b0;
            end else if (loop_open_i) begin
                call_reg <= 1'b1;
            end else begin
                call_reg <= (state_reg == ldct_pkg::LDCT_ST_CALL) ||
                            (state_reg == ldct_pkg::LDCT_ST_EXTEND) ||
                            (state_reg == ldct_pkg::LDCT_ST_PULSE);
            end
            led_o    <= detect && mode != ldct_pkg::LDCT_MODE_OFF;
            detect_o <= detect;
            tuned_o  <= state_reg != ldct_pkg::LDCT_ST_TUNE;
        end
    end

    assign call_n_o = ~call_reg;
endmodule

// *** pkg/ldct_map.svh ***
`ifndef LDCT_MAP_SVH
`define LDCT_MAP_SVH

// ----------------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------------
`define LDCT_CLK_HZ          40000000
`define LDCT_TICK_MS         10
`define LDCT_TICK_CYC        ((`LDCT_CLK_HZ / 1000) * `LDCT_TICK_MS)
`define LDCT_PULSE_MS        100
`define LDCT_PULSE_TICKS     (`LDCT_PULSE_MS / `LDCT_TICK_MS)
`define LDCT_QSEC_TICKS      25
`define LDCT_SEC_TICKS       100
`define LDCT_DELAY_MAX_S     30
`define LDCT_DELAY_CAP_S     63
`define LDCT_EXT_MAX_Q       63
`define LDCT_TUNE_MS         2000
`define LDCT_TUNE_TICKS      (`LDCT_TUNE_MS / `LDCT_TICK_MS)
`define LDCT_HOLD_TICKS      18000

// ----------------------------------------------------------------------
// sensitivity thresholds, in units of 0.001 percent change
// ----------------------------------------------------------------------
`define LDCT_THR_LOW         16'h00fa
`define LDCT_THR_MID         16'h0064
`define LDCT_THR_HIGH        16'h0014
`define LDCT_THR_FLOOR       16'h0064
`define LDCT_TRACK_STEP      16'h0001

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define LDCT_REG_CTRL        8'h00
`define LDCT_REG_STAT        8'h04
`define LDCT_REG_CHCFG0      8'h10
`define LDCT_CHCFG_STRIDE    8'h04
`define LDCT_CTRL_DELAY_EN   0
`define LDCT_CTRL_EXT_EN     1
`define LDCT_CFG_MODE_LSB    0
`define LDCT_CFG_SENS_LSB    2
`define LDCT_CFG_FREQ_LSB    4
`define LDCT_CFG_DELAY_LSB   8
`define LDCT_CFG_EXT_LSB     16
`define LDCT_CFG_RESET       32'h00000001

`endif

// *** pkg/ldct_pkg.sv ***
package ldct_pkg;
    typedef enum logic [1:0] {
        LDCT_MODE_OFF      = 2'h0,
        LDCT_MODE_PRESENCE = 2'h1,
        LDCT_MODE_PULSE    = 2'h2
    } ldct_mode_t;

    typedef enum logic [1:0] {
        LDCT_SENS_LOW  = 2'h0,
        LDCT_SENS_MID  = 2'h1,
        LDCT_SENS_HIGH = 2'h2
    } ldct_sens_t;

    typedef enum {
        LDCT_ST_TUNE,
        LDCT_ST_IDLE,
        LDCT_ST_DELAY,
        LDCT_ST_CALL,
        LDCT_ST_EXTEND,
        LDCT_ST_PULSE,
        LDCT_ST_WAIT_CLEAR
    } ldct_state_t;
endpackage

// *** src/ldct_top.sv ***
`include "ldct_map.svh"

// How it works
// - a per-channel mode field selects presence or pulse call operation.
// - pulse mode gives one call pulse of 100 ms per detection.
// - the off mode disables the channel so it never calls.
// - optional delay withholds the call after entry, never beyond 63 s.
// - delay is set 0 to 30 s in one-second steps.
// - optional extension holds the call after the vehicle leaves.
// - extension is set 0 to 15.75 s in quarter-second steps.
// - delay and extension enables are module wide, shared by all channels.
// - each channel has three selectable sensitivity thresholds.
// - change over threshold drives the active-low call within 20 ms.
// - when the change goes the call releases within 20 ms.
// - least sensitive setting holds a 1.0 percent call three minutes.
// - most sensitive setting holds a 0.02 percent call three minutes.
// - an open loop forces a continuous call unless the mode is off.
// - channels self-tune after power up, well inside three minutes.
// - after reset each channel retunes and resumes with no help.
// - each channel drives a detection indicator.
// - lowest sensitivity ignores changes below 0.1 percent.
// - tracking follows drift of 0.001 percent per second silently.
// - each channel selects among at least three loop frequencies.
module ldct_top #(
    parameter int NCH      = 4,
    parameter int TICK_CYC = `LDCT_TICK_CYC
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [31:0]      wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    output logic                  wb_ack_o,
    input  wire logic [NCH*16-1:0] change_i,
    input  wire logic [NCH-1:0]   loop_open_i,
    output logic      [NCH*2-1:0] freq_sel_o,
    output logic      [NCH-1:0]   call_n_o,
    output logic      [NCH-1:0]   led_o
);
    // ------------------------------------------------------------------
    // common time base
    // ------------------------------------------------------------------
    logic [18:0] div_reg;
    logic [6:0]  sub_reg;
    logic        tick;
    logic        qsec;
    logic        sec;
    logic [1:0]  q_reg;

    assign tick = div_reg == 19'(TICK_CYC - 1);
    assign qsec = tick && sub_reg == 7'(`LDCT_QSEC_TICKS - 1);
    assign sec  = qsec && q_reg == 2'h3;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 19'h00000;
            sub_reg <= 7'h00;
            q_reg   <= 2'h0;
        end else begin
            div_reg <= tick ? 19'h00000 : div_reg + 19'h00001;
            if (tick) begin
                sub_reg <= qsec ? 7'h00 : sub_reg + 7'h01;
            end
            if (qsec) begin
                q_reg <= q_reg + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [1:0]  ctrl_reg;
    logic [31:0] cfg_reg [NCH];
    logic [NCH-1:0] tuned;
    logic [NCH-1:0] det;
    logic        req;
    logic [7:0]  adr;
    logic [31:0] rd_next;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign adr = wb_adr_i[7:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= 2'h0;
        end else if (req && wb_we_i && wb_sel_i[0] && adr == `LDCT_REG_CTRL) begin
            ctrl_reg <= wb_dat_i[1:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic [7:0] cfg_adr;
            assign cfg_adr = `LDCT_REG_CHCFG0 + 8'(g * `LDCT_CHCFG_STRIDE);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cfg_reg[g] <= `LDCT_CFG_RESET;
                end else if (req && wb_we_i && adr == cfg_adr) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) begin
                            cfg_reg[g][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                        end
                    end
                end
            end
            assign freq_sel_o[g*2 +: 2] = cfg_reg[g][`LDCT_CFG_FREQ_LSB +: 2];

            ldct_channel u_ch (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .tick_i      (tick),
                .qsec_i      (qsec),
                .sec_i       (sec),
                .change_i    (change_i[g*16 +: 16]),
                .loop_open_i (loop_open_i[g]),
                .cfg_i       (cfg_reg[g]),
                .delay_en_i  (ctrl_reg[`LDCT_CTRL_DELAY_EN]),
                .ext_en_i    (ctrl_reg[`LDCT_CTRL_EXT_EN]),
                .call_n_o    (call_n_o[g]),
                .led_o       (led_o[g]),
                .tuned_o     (tuned[g]),
                .detect_o    (det[g])
            );
        end
    endgenerate

    always_comb begin
        rd_next = 32'h00000000;
        if (adr == `LDCT_REG_CTRL) begin
            rd_next = {30'h00000000, ctrl_reg};
        end else if (adr == `LDCT_REG_STAT) begin
            rd_next = {16'h0000, 8'(tuned), 8'(det)};
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (adr == `LDCT_REG_CHCFG0 + 8'(i * `LDCT_CHCFG_STRIDE)) begin
                    rd_next = cfg_reg[i];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= rd_next;
        end
    end
endmodule

// *** verif/ldct_top_checker.sv ***
`include "ldct_map.svh"

module ldct_top_checker #(
    parameter int NCH = 4
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic [31:0]        wb_adr_i,
    input  wire logic [31:0]        wb_dat_i,
    input  wire logic [31:0]        wb_dat_o,
    input  wire logic               wb_we_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_ack_o,
    input  wire logic [NCH*16-1:0]  change_i,
    input  wire logic [NCH-1:0]     loop_open_i,
    input  wire logic [NCH*2-1:0]   freq_sel_o,
    input  wire logic [NCH-1:0]     call_n_o,
    input  wire logic [NCH-1:0]     led_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ----------------------------------------------------------------
    // shadow of channel 0 mode and extension enable
    // ----------------------------------------------------------------
    logic [1:0] mode0_reg;
    logic       ext_reg;
    logic       wr_ack;
    assign wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode0_reg <= 2'h1;
            ext_reg   <= 1'b0;
        end else if (wr_ack && wb_adr_i[7:0] == `LDCT_REG_CHCFG0) begin
            mode0_reg <= wb_dat_i[1:0];
        end else if (wr_ack && wb_adr_i[7:0] == `LDCT_REG_CTRL) begin
            ext_reg <= wb_dat_i[1];
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ack_cause;
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    property p_unmapped;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
        !(wb_adr_i[7:0] inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c})
        |=> wb_dat_o == 32'h0;
    endproperty
    property p_reset_vals;
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> call_n_o == '1 && led_o == '0 && !wb_ack_o && freq_sel_o == '0;
    endproperty
    property p_freq0;
        wr_ack && wb_adr_i[7:0] == `LDCT_REG_CHCFG0
        |=> ##1 freq_sel_o[1:0] == $past(wb_dat_i[5:4], 2);
    endproperty
    property p_off_quiet;
        mode0_reg == 2'h0 && $past(mode0_reg) == 2'h0 && $past(mode0_reg, 2) == 2'h0
        |-> call_n_o[0];
    endproperty
    property p_failsafe;
        (loop_open_i[0] && mode0_reg != 2'h0) [*4] |-> !call_n_o[0];
    endproperty
    property p_release;
        (!loop_open_i[0] && change_i[15:0] == 16'h0 && !ext_reg && mode0_reg == 2'h1) [*4]
        |-> call_n_o[0];
    endproperty

    a_ack_next:   assert property (p_ack_next) else $error("ack missing after request");
    a_ack_pulse:  assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_cause:  assert property (p_ack_cause) else $error("ack without request");
    a_unmapped:   assert property (p_unmapped) else $error("unmapped read not zero");
    a_reset_vals: assert property (p_reset_vals) else $error("outputs not cleared by reset");
    a_freq0:      assert property (p_freq0) else $error("frequency select not updated");
    a_off_quiet:  assert property (p_off_quiet) else $error("call from disabled channel");
    a_failsafe:   assert property (p_failsafe) else $error("no call on open loop");
    a_release:    assert property (p_release) else $error("call not released");

    c_write:    cover property (wr_ack);
    c_failsafe: cover property (loop_open_i[0] && !call_n_o[0]);
    c_off:      cover property (loop_open_i[0] && mode0_reg == 2'h0);
endmodule

bind ldct_top ldct_top_checker #(.NCH(NCH)) u_ldct_top_checker (.*);

// *** verif/ldct_call_sink.sv ***
module ldct_call_sink #(
    parameter int NCH = 4
) (
    input  wire logic           clk_i,
    input  wire logic [NCH-1:0] call_n_i,
    output logic      [7:0]     calls_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // controller input: counts call onsets on channel 0
    // ----------------------------------------------------------------
    logic prev_reg;
    initial begin
        calls_o  = 8'h00;
        prev_reg = 1'b1;
    end
    always @(posedge clk_i) begin
        if (prev_reg === 1'b1 && call_n_i[0] === 1'b0) begin
            calls_o <= calls_o + 8'h01;
        end
        prev_reg <= call_n_i[0];
    end
endmodule

// *** verif/tb_ldct_top.sv ***
`include "ldct_map.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_ldct_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NCH = 4;
    logic             clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [31:0]      wb_adr_i, wb_dat_i, wb_dat_o, rd, exp_cfg;
    logic [3:0]       wb_sel_i, call_n_o, led_o, loop_open_i;
    logic [NCH*16-1:0] change_i;
    logic [7:0]       freq_sel_o, exp_f, calls;
    int               failures, comparisons;

    ldct_top #(.NCH(NCH), .TICK_CYC(20)) u_ldct_top (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .change_i(change_i),
        .loop_open_i(loop_open_i), .freq_sel_o(freq_sel_o), .call_n_o(call_n_o), .led_o(led_o));
    ldct_call_sink #(.NCH(NCH)) u_ldct_call_sink (.clk_i(clk_i), .call_n_i(call_n_o),
        .calls_o(calls));

    initial clk_i = 1'b0;
    always #12.5 clk_i = ~clk_i;

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    function automatic logic [7:0] cfg(input int n);
        return 8'(`LDCT_REG_CHCFG0 + `LDCT_CHCFG_STRIDE * n);
    endfunction
    task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic w);
        int n;
        n = 0;
        wb_adr_i <= {24'h0, a};
        wb_dat_i <= d;
        wb_sel_i <= s;
        wb_we_i  <= w;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        `CHK(n, 2)
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        xfer(a, d, s, 1'b1);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 32'h0, 4'hf, 1'b0);
        `CHK(rd, e)
    endtask
    task automatic settle();
        repeat (4) @(posedge clk_i);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        failures = 0;
        comparisons = 0;
        rst_i = 1'b1;
        wb_adr_i = 32'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        {wb_we_i, wb_cyc_i, wb_stb_i} = 3'h0;
        change_i = '0;
        loop_open_i = 4'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK(call_n_o, 4'hf)
        `CHK(led_o, 4'h0)
        `CHK(freq_sel_o, 8'h00)
        rdchk(`LDCT_REG_CTRL, 32'h0);
        rdchk(`LDCT_REG_STAT, 32'h0);
        for (int n = 0; n < NCH; n++) rdchk(cfg(n), `LDCT_CFG_RESET);
        $display("test reset_values done");

        wr(`LDCT_REG_CTRL, 32'h3, 4'h1);
        rdchk(`LDCT_REG_CTRL, 32'h3);
        wr(`LDCT_REG_STAT, 32'hffffffff, 4'hf);
        rdchk(`LDCT_REG_STAT, 32'h0);
        wr(8'h08, 32'hffffffff, 4'hf);
        rdchk(8'h08, 32'h0);
        exp_f = 8'h00;
        for (int n = 0; n < NCH; n++) begin
            exp_cfg = (32'(n * 21) << 16) | (32'(n * 10) << 8) | (32'(n % 3) << 4) | 32'h1;
            exp_f[2*n+:2] = 2'(n % 3);
            wr(cfg(n), exp_cfg, 4'hf);
            rdchk(cfg(n), exp_cfg);
        end
        `CHK(freq_sel_o, exp_f)
        wr(cfg(0), 32'h00050000, 4'h4);
        rdchk(cfg(0), 32'h00050001);
        $display("test registers done");

        wr(`LDCT_REG_CTRL, 32'h0, 4'h1);
        for (int m = 0; m < 3; m++) begin
            wr(cfg(0), 32'(m), 4'h1);
            loop_open_i[0] <= 1'b1;
            settle();
            `CHK(call_n_o, {3'h7, m == 0})
            loop_open_i[0] <= 1'b0;
            settle();
            `CHK(call_n_o, 4'hf)
        end
        `CHK(calls, 8'h02)
        $display("test failsafe_modes done");

        wr(cfg(0), 32'h1, 4'h1);
        loop_open_i[0] <= 1'b1;
        settle();
        `CHK(call_n_o[0], 1'b0)
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        `CHK(call_n_o, 4'hf)
        rst_i <= 1'b0;
        settle();
        `CHK(call_n_o[0], 1'b0)
        rdchk(cfg(1), `LDCT_CFG_RESET);
        rdchk(`LDCT_REG_CTRL, 32'h0);
        loop_open_i[0] <= 1'b0;
        settle();
        `CHK(call_n_o, 4'hf)
        `CHK(calls, 8'h04)
        $display("test mid_reset done");

        repeat (4100) @(posedge clk_i);
        rdchk(`LDCT_REG_STAT, 32'h00000f00);
        change_i[15:0] <= 16'h0063;
        settle();
        `CHK({call_n_o, led_o}, 8'hf0)
        change_i[15:0] <= 16'h03e8;
        settle();
        `CHK({call_n_o, led_o}, 8'he1)
        rdchk(`LDCT_REG_STAT, 32'h00000f01);
        change_i[15:0] <= 16'h0000;
        settle();
        `CHK({call_n_o, led_o}, 8'hf0)
        $display("test detection done");

        wr(cfg(0), 32'h2, 4'h1);
        change_i[15:0] <= 16'h03e8;
        repeat (154) @(posedge clk_i);
        `CHK(call_n_o, 4'he)
        repeat (100) @(posedge clk_i);
        `CHK(call_n_o, 4'hf)
        change_i[15:0] <= 16'h0000;
        wr(`LDCT_REG_CTRL, 32'h3, 4'h1);
        wr(cfg(0), 32'h00010101, 4'hf);
        change_i[15:0] <= 16'h03e8;
        settle();
        `CHK(call_n_o, 4'hf)
        repeat (2100) @(posedge clk_i);
        `CHK(call_n_o, 4'he)
        change_i[15:0] <= 16'h0000;
        settle();
        `CHK(call_n_o, 4'he)
        repeat (600) @(posedge clk_i);
        `CHK(call_n_o, 4'hf)
        `CHK(calls, 8'h07)
        $display("test timing done");
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        tally_and_finish();
    end
endmodule
